/* File: hw/can_pkg.sv */
// Purpose: Shared constants for the message-buffer control block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, word aligned
// Notes:   Lower arbitration key means higher bus priority
package can_pkg;
  localparam int          NUM_BUF      = 16;
  localparam int          IDX_W        = 4;
  // Register byte offsets
  localparam logic [7:0]  GCS_OFS      = 8'h00;
  localparam logic [7:0]  GCTL_OFS     = 8'h04;
  localparam logic [7:0]  MCTL_OFS     = 8'h08;
  localparam logic [7:0]  ERC_OFS      = 8'h0C;
  localparam logic [7:0]  INFO_OFS     = 8'h10;
  localparam logic [1:0]  RGN_GLOBAL   = 2'h0;
  localparam logic [1:0]  RGN_CONF     = 2'h1;
  localparam logic [1:0]  RGN_CTRL     = 2'h2;
  localparam logic [1:0]  RGN_ID       = 2'h3;
  // Buffer control fields: clear at POS, set at POS + 8
  localparam int          CTL_RDY      = 0;
  localparam int          CTL_TRQ      = 1;
  localparam int          CTL_DN       = 2;
  localparam int          CTL_IE       = 3;
  localparam int          CTL_MOW      = 4;
  localparam int          CTL_SET      = 8;
  // Buffer config fields
  localparam int          CFG_USE      = 0;
  localparam int          CFG_TYPE     = 3;
  localparam int          CFG_OWS      = 7;
  // Buffer identifier fields
  localparam int          ID_RTR       = 30;
  localparam int          ID_IDE       = 31;
  // Module control fields
  localparam int          MCTL_PEND    = 8;
  localparam int          MCTL_ERROR_COUNTER_CLEAR   = 15;
  localparam int          GCTL_EN      = 0;
  // Operating modes
  localparam logic [2:0]  MODE_INIT    = 3'h0;
  localparam logic [2:0]  MODE_NORMAL  = 3'h1;
  localparam logic [2:0]  MODE_ABT     = 3'h2;
  localparam logic [2:0]  MODE_RXONLY  = 3'h3;
  localparam logic [2:0]  MODE_SSHOT   = 3'h4;
  localparam logic [2:0]  MODE_SELF    = 3'h5;
  // Buffer types
  localparam logic [2:0]  TYPE_TX      = 3'h0;
  localparam logic [2:0]  TYPE_RX      = 3'h1;
  localparam logic [2:0]  TYPE_RX_LAST = 3'h5;
  localparam logic [2:0]  TYPE_MASK1   = 3'h2;
  // Reset values and limits
  localparam logic [3:0]  GCS_RST      = 4'hF;
  localparam logic [15:0] ERC_MAX      = 16'hFFFF;
  localparam logic [15:0] ERC_PASSIVE  = 16'h0080;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_INIT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_LEAVE = 2'b10
  } ctl_state_t;

  function automatic logic set_clr(input logic cur, input logic s,
                                   input logic c);
    if (s && !c) return 1'b1;
    if (!s && c) return 1'b0;
    return cur;
  endfunction

  // Arbitration field as sent on the wire, SRR and IDE included
  function automatic logic [31:0] arb_key(input logic [28:0] id,
                                          input logic ide, input logic rtr);
    if (ide) return {id[28:18], 1'b1, 1'b1, id[17:0], rtr};
    return {id[28:18], rtr, 1'b0, 18'h0, 1'b0};
  endfunction
endpackage

/* File: hw/can_rx_select.sv */
// Purpose: Pick the receive buffer for an incoming identifier
// Assumes: Masks arrive as four packed 29-bit vectors, 1 = ignore bit
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module can_rx_select import can_pkg::*; #(
  parameter int NUM = NUM_BUF
) (
  // Buffer state
  input  wire logic [NUM-1:0]        in_use,
  input  wire logic [NUM-1:0]        ready,
  input  wire logic [NUM-1:0]        new_data,
  input  wire logic [NUM-1:0]        overwrite_allow,
  input  wire logic [NUM-1:0][2:0]   btype,
  input  wire logic [NUM-1:0][28:0]  ids,
  input  wire logic [NUM-1:0]        ides,
  input  wire logic [3:0][28:0]      masks,
  // Received frame
  input  wire logic [28:0]           rx_id,
  input  wire logic                  rx_ide,
  // Result
  output logic                       hit,
  output logic                       store_ok,
  output logic [IDX_W-1:0]           index
);
  always_comb begin
    logic [2:0]  best;
    logic [28:0] care;
    logic        cand;
    best     = 3'h7;
    care     = '0;
    cand     = 1'b0;
    hit      = 1'b0;
    store_ok = 1'b0;
    index    = '0;
    for (int i = 0; i < NUM; i++) begin
      care = (btype[i] >= TYPE_MASK1) ? ~masks[btype[i] - TYPE_MASK1]
                                      : '1;
      if (!rx_ide) care[17:0] = '0;
      cand = in_use[i] && ready[i] && btype[i] >= TYPE_RX &&
             btype[i] <= TYPE_RX_LAST && ides[i] == rx_ide &&
             ((ids[i] ^ rx_id) & care) == '0;
      // Strict less keeps the lowest index inside one class
      if (cand && btype[i] < best) begin
        best     = btype[i];
        hit      = 1'b1;
        index    = IDX_W'(i);
        store_ok = !new_data[i] || overwrite_allow[i];
      end
    end
  end
endmodule

/* File: hw/can_tx_select.sv */
// Purpose: Pick the pending transmit buffer with best bus priority
// Assumes: Caller qualifies pending with in-use, type and ready
// Notes:   Ties go to the lowest buffer number
`timescale 1ns/1ps
module can_tx_select import can_pkg::*; #(
  parameter int NUM = NUM_BUF
) (
  // Buffer state
  input  wire logic [NUM-1:0]        pending,
  input  wire logic [NUM-1:0][28:0]  ids,
  input  wire logic [NUM-1:0]        ides,
  input  wire logic [NUM-1:0]        rtrs,
  // Result
  output logic                       hit,
  output logic [IDX_W-1:0]           index
);
  always_comb begin
    logic [31:0] best;
    logic [31:0] key;
    best  = '1;
    key   = '0;
    hit   = 1'b0;
    index = '0;
    for (int i = 0; i < NUM; i++) begin
      key = arb_key(ids[i], ides[i], rtrs[i]);
      if (pending[i] && (!hit || key < best)) begin
        best  = key;
        hit   = 1'b1;
        index = IDX_W'(i);
      end
    end
  end
endmodule

/* File: hw/can_msgbuf_ctrl.sv */
// Purpose: Message-buffer flags, mode control and buffer selection
// Assumes: Protocol engine on core_clk drives frame strobes and idle
// Notes:   Every access takes two cycles; waitrequest low in the second
//
// Functional notes
// - Writing 1 to new-data clear bit clears it; 0 leaves it.
// - Transmit-request follows set/clear pair; other combinations hold.
// - Ready flag follows set/clear pair; other combinations hold.
// - Setting the global enable bit enables the module.
// - Pending transmit buffer with highest bus priority is sent.
// - Three-bit mode field leaves init into one of five modes.
// - Init request waits for interframe space, then mode reads zero.
// - Error clear in init resets error count and status registers.
// - Receive search uses in-use, receive-typed, ready buffers only.
// - Only the highest priority candidate buffer may store.
// - Store only if new-data clear or overwrite allowed; else discard.
// - While ready, only ready, request, new-data, overwrite flags change; a store also rewrites the identifier.
// - Type codes: 0 transmit, 1 unmasked, 2 to 5 masks 1 to 4.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module can_msgbuf_ctrl import can_pkg::*; #(
  parameter int NUM = NUM_BUF
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  // Protocol engine side
  input  wire logic                  bus_in_ifs,
  input  wire logic                  rx_valid,
  input  wire logic [28:0]           rx_id,
  input  wire logic                  rx_ide,
  input  wire logic                  rx_rtr,
  input  wire logic [3:0][28:0]      rx_masks,
  input  wire logic                  tx_done,
  input  wire logic                  err_event,
  // Status towards the protocol engine
  output logic [2:0]                 operating_mode_field,
  output logic                       module_enabled,
  output logic [3:0]                 module_clock_prescale,
  output logic                       store_valid,
  output logic [IDX_W-1:0]           store_index,
  output logic                       rx_discard,
  output logic                       tx_valid,
  output logic [IDX_W-1:0]           tx_index
);
  initial begin
    if (NUM < 1 || NUM > (1 << IDX_W))
      $error("NUM must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // State
  ctl_state_t             st_q, st_d;
  logic [2:0]             mode_q, mode_d;
  logic [3:0]             gcs_q, gcs_d;
  logic [15:0]            erc_q, erc_d;
  logic [7:0]             info_q, info_d;
  logic                   wait_q, wait_d;
  logic [31:0]            rdata_q, rdata_d;
  logic [NUM-1:0]         rdy_q, rdy_d, trq_q, trq_d, dn_q, dn_d;
  logic [NUM-1:0]         ie_q, ie_d, mow_q, mow_d;
  logic [NUM-1:0]         use_q, use_d, ows_q, ows_d;
  logic [NUM-1:0]         ide_q, ide_d, rtr_q, rtr_d;
  logic [NUM-1:0][2:0]    type_q, type_d;
  logic [NUM-1:0][28:0]   id_q, id_d;
  logic                   stv_q, stv_d, disc_q, disc_d, txv_q, txv_d;
  logic [IDX_W-1:0]       sti_q, sti_d, txi_q, txi_d;

  ////////////////////////////////////////////////////////////////////////
  // Selection
  logic                   rx_hit, rx_ok, tx_hit;
  logic [IDX_W-1:0]       rx_idx, tx_idx;
  logic [NUM-1:0]         tx_pend;

  always_comb begin
    for (int i = 0; i < NUM; i++)
      tx_pend[i] = use_q[i] && type_q[i] == TYPE_TX && rdy_q[i] && trq_q[i];
  end

  can_rx_select #(.NUM(NUM)) u_rx (
    .in_use   (use_q),
    .ready    (rdy_q),
    .new_data (dn_q),
    .overwrite_allow      (ows_q),
    .btype    (type_q),
    .ids      (id_q),
    .ides     (ide_q),
    .masks    (rx_masks),
    .rx_id    (rx_id),
    .rx_ide   (rx_ide),
    .hit      (rx_hit),
    .store_ok (rx_ok),
    .index    (rx_idx)
  );

  can_tx_select #(.NUM(NUM)) u_tx (
    .pending (tx_pend),
    .ids     (id_q),
    .ides    (ide_q),
    .rtrs    (rtr_q),
    .hit     (tx_hit),
    .index   (tx_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  logic [1:0]             rgn;
  logic [3:0]             bidx;
  logic                   bsel;
  logic [31:0]            bmask, wd, rd_word;
  logic                   wr_go, active;

  assign rgn    = address[7:6];
  assign bidx   = address[5:2];
  assign bsel   = 32'(bidx) < NUM;
  assign bmask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wd     = writedata & bmask;
  // Access lands on the edge where waitrequest is seen low
  assign wr_go  = write && !wait_q;
  assign active = st_q == ST_RUN || st_q == ST_LEAVE;

  always_comb begin
    rd_word = '0;
    unique case (rgn)
      RGN_GLOBAL: begin
        if (address == GCS_OFS)  rd_word[3:0] = gcs_q;
        if (address == GCTL_OFS) rd_word[GCTL_EN] = st_q != ST_OFF;
        if (address == MCTL_OFS) begin
          rd_word[2:0]       = mode_q;
          rd_word[MCTL_PEND] = st_q == ST_LEAVE;
        end
        if (address == ERC_OFS)  rd_word[15:0] = erc_q;
        if (address == INFO_OFS) rd_word[7:0] = info_q;
      end
      RGN_CONF: if (bsel) begin
        rd_word[CFG_USE]             = use_q[bidx];
        rd_word[CFG_TYPE +: 3]       = type_q[bidx];
        rd_word[CFG_OWS]             = ows_q[bidx];
      end
      RGN_CTRL: if (bsel) begin
        rd_word[CTL_RDY] = rdy_q[bidx];
        rd_word[CTL_TRQ] = trq_q[bidx];
        rd_word[CTL_DN]  = dn_q[bidx];
        rd_word[CTL_IE]  = ie_q[bidx];
        rd_word[CTL_MOW] = mow_q[bidx];
      end
      RGN_ID: if (bsel) begin
        rd_word[28:0]   = id_q[bidx];
        rd_word[ID_RTR] = rtr_q[bidx];
        rd_word[ID_IDE] = ide_q[bidx];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((read || write) && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode control, clock select, error registers
  always_comb begin
    st_d   = st_q;
    mode_d = mode_q;
    gcs_d  = gcs_q;
    erc_d  = erc_q;
    info_d = info_q;
    if (err_event && active && erc_q != ERC_MAX) begin
      erc_d     = erc_q + 16'h0001;
      info_d[0] = erc_d >= ERC_PASSIVE;
    end
    // Prescale is frozen once enabled, guarding the running bit clock
    if (wr_go && address == GCS_OFS && st_q == ST_OFF)
      gcs_d = wd[3:0];
    unique case (st_q)
      ST_OFF:   ;
      ST_INIT: begin
        if (wr_go && address == MCTL_OFS) begin
          if (wd[MCTL_ERROR_COUNTER_CLEAR]) begin
            erc_d  = '0;
            info_d = '0;
          end
          if (wd[2:0] >= MODE_NORMAL && wd[2:0] <= MODE_SELF) begin
            mode_d = wd[2:0];
            st_d   = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // Mode-to-mode writes are ignored; only init is accepted
        if (wr_go && address == MCTL_OFS && wd[2:0] == MODE_INIT)
          st_d = ST_LEAVE;
      end
      ST_LEAVE: begin
        if (bus_in_ifs) begin
          st_d   = ST_INIT;
          mode_d = MODE_INIT;
        end
      end
    endcase
    if (wr_go && address == GCTL_OFS && byteenable[0]) begin
      if (wd[GCTL_EN] && st_q == ST_OFF) begin
        st_d   = ST_INIT;
        mode_d = MODE_INIT;
      end else if (!wd[GCTL_EN]) begin
        st_d   = ST_OFF;
        mode_d = MODE_INIT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer registers, frame storage and transmit choice
  always_comb begin
    rdy_d  = rdy_q;
    trq_d  = trq_q;
    dn_d   = dn_q;
    ie_d   = ie_q;
    mow_d  = mow_q;
    use_d  = use_q;
    ows_d  = ows_q;
    type_d = type_q;
    id_d   = id_q;
    ide_d  = ide_q;
    rtr_d  = rtr_q;
    stv_d  = 1'b0;
    disc_d = 1'b0;
    sti_d  = sti_q;
    txv_d  = active && tx_hit && mode_q != MODE_RXONLY;
    txi_d  = tx_hit ? tx_idx : txi_q;
    // Completion first, so a software set in the same cycle wins
    if (tx_done && txv_q)
      trq_d[txi_q] = 1'b0;
    if (wr_go && bsel) begin
      unique case (rgn)
        RGN_GLOBAL: ;
        RGN_CTRL: begin
          rdy_d[bidx] = set_clr(rdy_q[bidx], wd[CTL_SET + CTL_RDY],
                                wd[CTL_RDY]);
          trq_d[bidx] = set_clr(trq_d[bidx], wd[CTL_SET + CTL_TRQ],
                                wd[CTL_TRQ]);
          // Set position of new-data is not honoured
          if (wd[CTL_DN]) dn_d[bidx] = 1'b0;
          if (wd[CTL_MOW]) mow_d[bidx] = 1'b0;
          if (!rdy_q[bidx])
            ie_d[bidx] = set_clr(ie_q[bidx], wd[CTL_SET + CTL_IE],
                                 wd[CTL_IE]);
        end
        RGN_CONF: if (!rdy_q[bidx]) begin
          if (byteenable[0]) begin
            use_d[bidx]  = wd[CFG_USE];
            type_d[bidx] = wd[CFG_TYPE +: 3];
            ows_d[bidx]  = wd[CFG_OWS];
          end
        end
        RGN_ID: if (!rdy_q[bidx]) begin
          id_d[bidx]  = (id_q[bidx] & ~bmask[28:0]) | wd[28:0];
          if (byteenable[3]) begin
            rtr_d[bidx] = wd[ID_RTR];
            ide_d[bidx] = wd[ID_IDE];
          end
        end
      endcase
    end
    // Hardware store applied last: a set beats a same-cycle clear
    if (rx_valid && active && rx_hit) begin
      if (rx_ok) begin
        stv_d        = 1'b1;
        sti_d        = rx_idx;
        dn_d[rx_idx] = 1'b1;
        id_d[rx_idx] = rx_id;
        if (dn_q[rx_idx] && !rx_rtr)
          mow_d[rx_idx] = 1'b1;
      end else begin
        disc_d = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q    <= ST_OFF;
      mode_q  <= MODE_INIT;
      gcs_q   <= GCS_RST;
      erc_q   <= '0;
      info_q  <= '0;
      wait_q  <= 1'b1;
      rdata_q <= '0;
      rdy_q   <= '0;
      trq_q   <= '0;
      dn_q    <= '0;
      ie_q    <= '0;
      mow_q   <= '0;
      use_q   <= '0;
      ows_q   <= '0;
      type_q  <= '0;
      id_q    <= '0;
      ide_q   <= '0;
      rtr_q   <= '0;
      stv_q   <= 1'b0;
      disc_q  <= 1'b0;
      sti_q   <= '0;
      txv_q   <= 1'b0;
      txi_q   <= '0;
    end else begin
      st_q    <= st_d;
      mode_q  <= mode_d;
      gcs_q   <= gcs_d;
      erc_q   <= erc_d;
      info_q  <= info_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
      trq_q   <= trq_d;
      dn_q    <= dn_d;
      ie_q    <= ie_d;
      mow_q   <= mow_d;
      use_q   <= use_d;
      ows_q   <= ows_d;
      type_q  <= type_d;
      id_q    <= id_d;
      ide_q   <= ide_d;
      rtr_q   <= rtr_d;
      stv_q   <= stv_d;
      disc_q  <= disc_d;
      sti_q   <= sti_d;
      txv_q   <= txv_d;
      txi_q   <= txi_d;
    end
  end

  assign readdata              = rdata_q;
  assign waitrequest           = wait_q;
  assign operating_mode_field  = mode_q;
  assign module_enabled        = st_q != ST_OFF;
  assign module_clock_prescale = gcs_q;
  assign store_valid           = stv_q;
  assign store_index           = sti_q;
  assign rx_discard            = disc_q;
  assign tx_valid              = txv_q;
  assign tx_index              = txi_q;
endmodule

/* File: verification/can_msgbuf_checker.sv */
// Purpose: Port-level timing checks for the buffer control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every can_msgbuf_ctrl instance
`timescale 1ns/1ps
module can_msgbuf_checker import can_pkg::*; (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register bus
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  // Engine side and status
  input wire logic       bus_in_ifs,
  input wire logic       rx_valid,
  input wire logic [2:0] operating_mode_field,
  input wire logic       module_enabled,
  input wire logic [3:0] module_clock_prescale,
  input wire logic       store_valid,
  input wire logic       rx_discard
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  a_wait_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus request not answered");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  a_enable_init: assert property ($rose(module_enabled)
    |-> operating_mode_field == MODE_INIT) else $error("enable not init");
  a_init_at_ifs: assert property (module_enabled
    && operating_mode_field != MODE_INIT ##1 module_enabled
    && operating_mode_field == MODE_INIT |-> $past(bus_in_ifs))
    else $error("init entered outside interframe space");
  a_mode_held: assert property (module_enabled && !bus_in_ifs
    && operating_mode_field != MODE_INIT
    |=> !module_enabled || $stable(operating_mode_field))
    else $error("mode changed during a frame");
  a_mode_legal: assert property (operating_mode_field <= MODE_SELF)
    else $error("mode field out of range");
  a_store_cause: assert property (store_valid || rx_discard
    |-> $past(rx_valid)) else $error("store without a frame");
  a_store_excl: assert property (!(store_valid && rx_discard))
    else $error("frame both stored and discarded");
  a_clock_lock: assert property (module_enabled
    |=> !module_enabled || $stable(module_clock_prescale))
    else $error("prescale changed while enabled");
endmodule

bind can_msgbuf_ctrl can_msgbuf_checker u_can_msgbuf_checker (
  .core_clk, .rst_n, .read, .write, .waitrequest, .bus_in_ifs, .rx_valid,
  .operating_mode_field, .module_enabled, .module_clock_prescale,
  .store_valid, .rx_discard
);

/* File: verification/can_engine_model.sv */
// Purpose: Behavioural protocol engine facing the buffer control block
// Assumes: Bus idles in interframe space between frames
// Notes:   Mask 1 ignores every bit so it catches any identifier
`timescale 1ns/1ps
module can_engine_model import can_pkg::*; (
  // Clock
  input wire logic        core_clk,
  // Towards the controller
  output logic            bus_in_ifs,
  output logic            rx_valid,
  output logic [28:0]     rx_id,
  output logic            rx_ide,
  output logic            rx_rtr,
  output logic [3:0][28:0] rx_masks,
  output logic            tx_done,
  output logic            err_event,
  // From the controller
  input wire logic        store_valid,
  input wire logic        rx_discard
);
  int n_store = 0;
  int n_drop = 0;

  initial begin
    {bus_in_ifs, rx_valid, rx_ide, rx_rtr, tx_done, err_event} = 6'h20;
    rx_id = '0;
    rx_masks = {{3{29'h0}}, 29'h1FFFFFFF};
  end

  always @(posedge core_clk) begin
    if (store_valid === 1'b1) n_store++;
    if (rx_discard === 1'b1) n_drop++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic set_ifs(input logic v);
    @(posedge core_clk);
    bus_in_ifs <= v;
  endtask

  task automatic set_mask1(input logic [28:0] m);
    @(posedge core_clk);
    rx_masks[0] <= m;
  endtask

  // Interframe space drops for the whole frame; id scrambled after it
  task automatic frame(input logic [28:0] id, input logic ide,
                       input logic rtr);
    @(posedge core_clk);
    bus_in_ifs <= 1'b0;
    repeat (4) @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ide <= ide;
    rx_rtr <= rtr;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    bus_in_ifs <= 1'b1;
  endtask

  task automatic strobe(input logic done);
    @(posedge core_clk);
    if (done) tx_done <= 1'b1;
    else err_event <= 1'b1;
    @(posedge core_clk);
    tx_done <= 1'b0;
    err_event <= 1'b0;
  endtask
endmodule

/* File: verification/can_msgbuf_ctrl_init_rx_select_bench.sv */
// Purpose: Register-level tests of the buffer control block
// Assumes: Engine model idles in interframe space
// Notes:   Bus waits end on waitrequest or on the watchdog only
`timescale 1ns/1ps
module can_msgbuf_ctrl_init_rx_select_bench import can_pkg::*;;
  logic             core_clk, rst_n, read, write, waitrequest;
  logic [7:0]       address;
  logic [31:0]      writedata, readdata, rdata;
  logic [3:0]       byteenable, lanes = 4'hF;
  logic             bus_in_ifs, rx_valid, rx_ide, rx_rtr, tx_done;
  logic             err_event, module_enabled, store_valid, rx_discard;
  logic             tx_valid;
  logic [28:0]      rx_id;
  logic [3:0][28:0] rx_masks;
  logic [2:0]       operating_mode_field;
  logic [3:0]       module_clock_prescale;
  logic [IDX_W-1:0] store_index, tx_index;
  int               miscompares = 0;
  int               comparisons = 0;
  localparam logic [15:0] CW [10] = '{16'h0100, 16'h0101, 16'h0200,
    16'h0202, 16'h0002, 16'h0800, 16'h0001, 16'h0800, 16'h0008, 16'h0400};
  localparam logic [4:0] CE [10] = '{5'h01, 5'h01, 5'h03, 5'h03, 5'h01,
    5'h01, 5'h00, 5'h08, 5'h00, 5'h00};
  localparam logic [7:0] CF [6] = '{8'h09, 8'h11, 8'h01, 8'h01, 8'h89,
    8'h39};
  localparam logic [31:0] IDS [6] = '{32'h01000000, 32'h0AAAAAAA,
    32'h08000000, 32'h04000000, 32'h02000000, 32'h03000000};

  can_msgbuf_ctrl u_can_msgbuf_ctrl (.core_clk, .rst_n, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .bus_in_ifs,
    .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_masks, .tx_done, .err_event,
    .operating_mode_field, .module_enabled, .module_clock_prescale,
    .store_valid, .store_index, .rx_discard, .tx_valid, .tx_index);
  can_engine_model u_can_engine_model (.core_clk, .bus_in_ifs, .rx_valid,
    .rx_id, .rx_ide, .rx_rtr, .rx_masks, .tx_done, .err_event,
    .store_valid, .rx_discard);

  ////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge core_clk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= lanes;
    do @(posedge core_clk);
    while (waitrequest !== 1'b0);
    rdata = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    access(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    {read, write, address, writedata, byteenable} = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(GCS_OFS, {28'h0, GCS_RST});
    rd(8'h14, 32'h0);
    wr(8'h14, 32'h5);
    wr(GCS_OFS, 32'h3);
    wr(GCTL_OFS, 32'h1);
    rd(MCTL_OFS, 32'h0);
    wr(GCS_OFS, 32'h5);
    rd(GCS_OFS, 32'h3);
    chk({27'h0, module_enabled, module_clock_prescale}, 32'h13);
    for (int i = 0; i < 10; i++) begin
      wr(8'h80, {16'h0, CW[i]});
      rd(8'h80, {27'h0, CE[i]});
    end
    wr(8'h80, 32'h100);
    wr(8'h40, 32'h9);
    rd(8'h40, 32'h0);
    for (int i = 0; i < NUM_BUF; i++) begin
      wr(8'(8'h80 + 4 * i), 32'h17);
      wr(8'(8'h40 + 4 * i), 32'h0);
    end
    lanes = 4'h1;
    wr(8'hE0, 32'hFFFFFFFF);
    lanes = 4'hF;
    rd(8'hE0, 32'h000000FF);
    for (int i = 1; i <= 6; i++) begin
      wr(8'(8'h40 + 4 * i), {24'h0, CF[i-1]});
      wr(8'(8'hC0 + 4 * i), IDS[i-1]);
      wr(8'(8'h80 + 4 * i), 32'h100);
    end
    wr(8'h8C, 32'h200);
    wr(8'h90, 32'h200);
    for (int m = 1; m <= 5; m++) begin
      wr(MCTL_OFS, 32'(m));
      rd(MCTL_OFS, 32'(m));
      chk({29'h0, operating_mode_field}, 32'(m));
      wr(MCTL_OFS, 32'h0);
      rd(MCTL_OFS, 32'h0);
    end
    wr(MCTL_OFS, {29'h0, MODE_NORMAL});
    repeat (2) @(posedge core_clk);
    chk({31'h0, tx_valid}, 32'h1);
    chk({28'h0, tx_index}, 32'h4);
    u_can_engine_model.strobe(1'b1);
    rd(8'h90, 32'h1);
    chk({28'h0, tx_index}, 32'h3);
    u_can_engine_model.frame(29'h01000000, 1'b0, 1'b0);
    rd(8'h84, 32'h5);
    chk({28'h0, store_index}, 32'h1);
    u_can_engine_model.frame(29'h01000000, 1'b0, 1'b0);
    rd(8'h84, 32'h5);
    rd(8'h88, 32'h1);
    chk(u_can_engine_model.n_drop, 32'h1);
    wr(8'h84, 32'h4);
    rd(8'h84, 32'h1);
    u_can_engine_model.frame(29'h02000000, 1'b0, 1'b0);
    u_can_engine_model.frame(29'h02000000, 1'b0, 1'b0);
    rd(8'h94, 32'h15);
    u_can_engine_model.frame(29'h03000000, 1'b0, 1'b0);
    rd(8'h88, 32'h5);
    chk(u_can_engine_model.n_store, 32'h4);
    wr(8'h94, 32'h10);
    u_can_engine_model.frame(29'h02000000, 1'b0, 1'b1);
    rd(8'h94, 32'h5);
    u_can_engine_model.frame(29'h03000000, 1'b1, 1'b0);
    u_can_engine_model.set_mask1(29'h0);
    u_can_engine_model.frame(29'h05000000, 1'b0, 1'b0);
    chk(u_can_engine_model.n_store, 32'h5);
    chk(u_can_engine_model.n_drop, 32'h1);
    u_can_engine_model.strobe(1'b0);
    u_can_engine_model.strobe(1'b0);
    rd(ERC_OFS, 32'h2);
    u_can_engine_model.set_ifs(1'b0);
    wr(MCTL_OFS, 32'h0);
    rd(MCTL_OFS, 32'h101);
    u_can_engine_model.set_ifs(1'b1);
    rd(MCTL_OFS, 32'h0);
    wr(MCTL_OFS, 32'h8000);
    rd(ERC_OFS, 32'h0);
    rd(INFO_OFS, 32'h0);
    wr(GCTL_OFS, 32'h0);
    rd(GCTL_OFS, 32'h0);
    chk({31'h0, module_enabled}, 32'h0);
    end_of_test();
  end
endmodule
